// >>> slcrb_pkg.sv
// Package: offsets, fields, reset values and carriers for the loop configuration bank
package slcrb_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_SPREAD_A = 6'h20;
  localparam logic [5:0] IDX_SPREAD_B = 6'h21;
  localparam logic [5:0] IDX_SPREAD_C = 6'h22;
  localparam logic [5:0] IDX_FREQ_SEL = 6'h23;
  localparam logic [5:0] IDX_ROUTING = 6'h24;
  localparam logic [5:0] IDX_OUT_STATE_SEL = 6'h25;
  localparam logic [5:0] IDX_DIV_ONE = 6'h26;
  localparam logic [5:0] IDX_DIV_TWO = 6'h27;
  localparam logic [5:0] IDX_STATUS = 6'h30;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SPREAD_A = 8'h00;
  localparam logic [7:0] RST_SPREAD_B = 8'h00;
  localparam logic [7:0] RST_SPREAD_C = 8'h00;
  localparam logic [7:0] RST_FREQ_SEL = 8'h00;
  localparam logic [7:0] RST_ROUTING = 8'hed;
  localparam logic [7:0] RST_OUT_STATE_SEL = 8'h02;
  localparam logic [7:0] RST_DIV_ONE = 8'h01;
  localparam logic [7:0] RST_DIV_TWO = 8'h01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_BYPASS = 7;
  localparam int POS_OUT_A_SRC = 6;
  localparam int POS_OUT_B_SRC = 4;
  localparam int POS_STATE_ONE = 2;
  localparam int POS_STATE_ZERO = 0;
  localparam int POS_DOWN_CENTER = 7;
  localparam int SETTING_COUNT = 8;
  localparam int SPREAD_W = 3;
  localparam int DIV_W = 7;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OST_TRI_PD = 2'h0,
    OST_TRI = 2'h1,
    OST_LOW = 2'h2,
    OST_ON = 2'h3
  } slcrb_ostate_t;

  localparam logic [1:0] SRC_B_FIRST_LOOP = 2'h0;
  localparam logic [1:0] SRC_B_DIV_ONE = 2'h1;
  localparam logic [1:0] SRC_B_DIV_TWO = 2'h2;
  localparam logic [1:0] SRC_B_RESERVED = 2'h3;

  // ----------------------------------------------------------------
  // Active configuration carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] spread_amount_setting;
    logic spread_down_center_select;
    logic loop_freq_select_bit;
    logic loop_bypass_select;
    logic loop_power_down;
    logic output_a_source_select;
    logic [1:0] output_b_source_select;
    logic output_b_source_reserved;
    logic outputs_enabled;
    logic outputs_low;
    logic outputs_tristate;
    logic [6:0] local_output_divider_one;
    logic divider_one_standby;
    logic [6:0] local_output_divider_two;
    logic divider_two_standby;
  } slcrb_cfg_t;

endpackage : slcrb_pkg

// >>> slcrb_top.sv
// Register bank and active-setting decode for the second synthesizer loop
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
// Notes on behaviour
// R1: Eight three-bit spread amounts; 000 off, 001..111 from 0.25% to 2.0%.
// R2: Down/center bit: 0 downward spread, 1 centered; resets to 0.
// R3: Per-setting frequency bit: 0 first multiplier/divider set, 1 the second.
// R4: Bypass bit 0 routes the loop, 1 bypasses and powers it down; resets 1.
// R5: Output A source: 0 first-loop divider, 1 local divider one; resets 1.
// R6: Output B source: 00 first loop, 01 divider one, 10 divider two; 11 reserved.
// R7: Output state 00 tri-state plus power down, 01 tri-state, 10 low, 11 on.
// R8: Per-setting output-state bit picks definition zero or one; setting one resets 1.
// R9: Three control pins choose which of eight settings is active.
// R10: Index is {pin two, pin one, pin zero}, resampled on the local clock.
// R11: Host must not write data beyond offset 40h.
// R12: Register data bytes travel most significant bit first.
// R13: Divider value 0 means reset and standby; 1 to 127 is the ratio.
module slcrb_top
  import slcrb_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pins, asynchronous to pclk
  input wire logic control_pin_zero,
  input wire logic control_pin_one,
  input wire logic control_pin_two,
  // Active configuration
  output slcrb_cfg_t active_cfg
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] spread_a_r;
  logic [7:0] spread_b_r;
  logic [7:0] spread_c_r;
  logic [7:0] freq_sel_r;
  logic [7:0] routing_r;
  logic [7:0] state_sel_r;
  logic [7:0] div_one_r;
  logic [7:0] div_two_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  slcrb_cfg_t cfg_r;
  slcrb_cfg_t cfg_nxt;

  logic [5:0] idx;
  logic aligned;
  logic mapped;
  logic wr_en;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic [23:0] spread_all;
  logic [2:0] spread_of [SETTING_COUNT];
  logic [2:0] sel;
  logic [1:0] def_zero;
  logic [1:0] def_one;
  logic [1:0] ostate;

  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wbyte = pwdata[7:0];
  assign wr_en = psel && penable && pwrite && pstrb[0] && mapped;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    case (idx)
      IDX_SPREAD_A, IDX_SPREAD_B, IDX_SPREAD_C, IDX_FREQ_SEL,
      IDX_ROUTING, IDX_OUT_STATE_SEL, IDX_DIV_ONE, IDX_DIV_TWO,
      IDX_STATUS: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Status is read-only; a write there is accepted and dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spread_a_r <= RST_SPREAD_A;
      spread_b_r <= RST_SPREAD_B;
      spread_c_r <= RST_SPREAD_C;
      freq_sel_r <= RST_FREQ_SEL;
      routing_r <= RST_ROUTING; // R4 R5 R6 R7
      state_sel_r <= RST_OUT_STATE_SEL; // R8
      div_one_r <= RST_DIV_ONE; // R2
      div_two_r <= RST_DIV_TWO;
    end else if (wr_en) begin
      case (idx)
        IDX_SPREAD_A: spread_a_r <= wbyte;
        IDX_SPREAD_B: spread_b_r <= wbyte;
        IDX_SPREAD_C: spread_c_r <= wbyte;
        IDX_FREQ_SEL: freq_sel_r <= wbyte;
        IDX_ROUTING: routing_r <= wbyte;
        IDX_OUT_STATE_SEL: state_sel_r <= wbyte;
        IDX_DIV_ONE: div_one_r <= wbyte;
        // Top bit is reserved and held at zero
        IDX_DIV_TWO: div_two_r <= {1'b0, wbyte[6:0]};
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    case (idx)
      IDX_SPREAD_A: rd_byte = spread_a_r;
      IDX_SPREAD_B: rd_byte = spread_b_r;
      IDX_SPREAD_C: rd_byte = spread_c_r;
      IDX_FREQ_SEL: rd_byte = freq_sel_r;
      IDX_ROUTING: rd_byte = routing_r;
      IDX_OUT_STATE_SEL: rd_byte = state_sel_r;
      IDX_DIV_ONE: rd_byte = div_one_r;
      IDX_DIV_TWO: rd_byte = div_two_r;
      IDX_STATUS: rd_byte = {2'h0, ostate, cfg_r.loop_freq_select_bit, sel};
      default: rd_byte = 8'h00;
    endcase
  end

  // Data is captured in the setup cycle so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000; // R12
      pslverr_r <= !mapped;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Control pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {control_pin_two, control_pin_one, control_pin_zero}; // R10
      pin_sync_r <= pin_meta_r;
    end
  end

  assign sel = pin_sync_r; // R9

  // ----------------------------------------------------------------
  // Per-setting spread fields
  // ----------------------------------------------------------------
  // Setting seven sits at the top of the first byte; fields straddle bytes.
  assign spread_all = {spread_a_r, spread_b_r, spread_c_r};

  for (genvar k = 0; k < SETTING_COUNT; k++) begin : g_spread
    assign spread_of[k] = spread_all[SPREAD_W*k +: SPREAD_W]; // R1
  end

  // ----------------------------------------------------------------
  // Active configuration decode
  // ----------------------------------------------------------------
  assign def_zero = routing_r[POS_STATE_ZERO +: 2];
  assign def_one = routing_r[POS_STATE_ONE +: 2];
  assign ostate = state_sel_r[sel] ? def_one : def_zero; // R8

  always_comb begin
    cfg_nxt = '0;
    cfg_nxt.spread_amount_setting = spread_of[sel]; // R1 R9
    cfg_nxt.spread_down_center_select = div_one_r[POS_DOWN_CENTER]; // R2
    cfg_nxt.loop_freq_select_bit = freq_sel_r[sel]; // R3
    cfg_nxt.loop_bypass_select = routing_r[POS_BYPASS]; // R4
    cfg_nxt.output_a_source_select = routing_r[POS_OUT_A_SRC]; // R5
    cfg_nxt.output_b_source_select = routing_r[POS_OUT_B_SRC +: 2]; // R6
    cfg_nxt.output_b_source_reserved =
      (routing_r[POS_OUT_B_SRC +: 2] == SRC_B_RESERVED); // R6
    case (slcrb_ostate_t'(ostate))
      OST_TRI_PD: cfg_nxt.outputs_tristate = 1'b1; // R7
      OST_TRI: cfg_nxt.outputs_tristate = 1'b1; // R7
      OST_LOW: cfg_nxt.outputs_low = 1'b1; // R7
      OST_ON: cfg_nxt.outputs_enabled = 1'b1; // R7
      default: cfg_nxt.outputs_tristate = 1'b1;
    endcase
    // Bypass and the tri-state/power-down definition both stop the loop
    cfg_nxt.loop_power_down = routing_r[POS_BYPASS] ||
      (slcrb_ostate_t'(ostate) == OST_TRI_PD); // R4 R7
    cfg_nxt.local_output_divider_one = div_one_r[DIV_W-1:0]; // R13
    cfg_nxt.divider_one_standby = (div_one_r[DIV_W-1:0] == 7'h00); // R13
    cfg_nxt.local_output_divider_two = div_two_r[DIV_W-1:0]; // R13
    cfg_nxt.divider_two_standby = (div_two_r[DIV_W-1:0] == 7'h00); // R13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign active_cfg = cfg_r;

endmodule : slcrb_top

// >>> slcrb_props.sv
// Checker: port properties of the loop configuration bank
`timescale 1ns/100ps
module slcrb_props
  import slcrb_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and configuration
  input wire logic control_pin_zero,
  input wire logic control_pin_one,
  input wire logic control_pin_two,
  input wire slcrb_cfg_t active_cfg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready) else $error("pready low");
  a_lane_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper lanes set");
  a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_bypass_power: assert property ($past(presetn) && active_cfg.loop_bypass_select
    |-> active_cfg.loop_power_down) else $error("bypass without power down");
  a_state_exclusive: assert property ($onehot0({active_cfg.outputs_enabled,
    active_cfg.outputs_low, active_cfg.outputs_tristate})) else $error("output states");
  a_reserved_flag: assert property ($past(presetn) |-> active_cfg.output_b_source_reserved
    == (active_cfg.output_b_source_select == 2'h3)) else $error("reserved flag");
  a_div_one_standby: assert property ($past(presetn) |-> active_cfg.divider_one_standby
    == (active_cfg.local_output_divider_one == 7'h0)) else $error("divider one");
  a_div_two_standby: assert property ($past(presetn) |-> active_cfg.divider_two_standby
    == (active_cfg.local_output_divider_two == 7'h0)) else $error("divider two");
  a_cfg_hold: assert property ((!psel && $stable({control_pin_two, control_pin_one,
    control_pin_zero}))[*4] |-> $stable(active_cfg)) else $error("config moved");
endmodule : slcrb_props

bind slcrb_top slcrb_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .control_pin_zero(control_pin_zero), .control_pin_one(control_pin_one),
  .control_pin_two(control_pin_two), .active_cfg(active_cfg));

// >>> slcrb_host.sv
// Host model: APB master that programs the bank
`timescale 1ns/100ps
module slcrb_host (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h1;
  end
  // Byte sits in the low lane, its bit 7 first in significance
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look valid
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : slcrb_host

// >>> tb_second_synth_loop_config_register_bank.sv
// Testbench: register bank reset, readback, setting selection and decode
`timescale 1ns/100ps
module tb_second_synth_loop_config_register_bank;
  import slcrb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [2:0] pins;
  slcrb_cfg_t cfg;
  logic [32:0] exp_q[$];
  int fail_count, cmp_count;
  logic [23:0] spr;
  logic [7:0] fs, os;
  logic [1:0] code;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hed, 8'h02, 8'h01, 8'h01};
  slcrb_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));
  slcrb_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .control_pin_zero(pins[0]),
    .control_pin_one(pins[1]), .control_pin_two(pins[2]), .active_cfg(cfg));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(string n, logic [32:0] s, logic [32:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 8'h00);
  endtask : rd
  // Monitor: each completed read retires the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk("unexpected read", 1, 0);
      else chk("read", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    pins = 3'h0;
    void'($urandom(32'hda656716));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("reset decode", {cfg.loop_bypass_select, cfg.output_a_source_select,
      cfg.output_b_source_select, cfg.outputs_tristate}, 5'h1d);
    for (int i = 0; i < 8; i++) rd(8'h80 + 8'(4 * i), {25'h0, rst_tab[i]});
    rd(8'h00, 33'h100000000);
    rd(8'h82, 33'h100000000);
    spr = 24'($urandom);
    fs = 8'($urandom);
    os = 8'($urandom);
    u_host.xfer(1'b1, 8'h80, spr[23:16]);
    u_host.xfer(1'b1, 8'h84, spr[15:8]);
    u_host.xfer(1'b1, 8'h88, spr[7:0]);
    u_host.xfer(1'b1, 8'h8c, fs);
    u_host.xfer(1'b1, 8'h94, os);
    rd(8'h84, {25'h0, spr[15:8]});
    for (int k = 0; k < 8; k++) begin
      u_host.xfer(1'b1, 8'h90, {1'b0, k[0], k[1:0], 2'h3, k[2:1]});
      pins <= 3'(k);
      repeat (5) @(posedge pclk);
      code = os[k] ? 2'h3 : k[2:1];
      chk("spread", cfg.spread_amount_setting, spr[3 * k +: 3]);
      chk("freq", cfg.loop_freq_select_bit, fs[k]);
      chk("sources", {cfg.output_a_source_select, cfg.output_b_source_select,
        cfg.output_b_source_reserved}, {k[0], k[1:0], k[1:0] == 2'h3});
      chk("state", {cfg.outputs_enabled, cfg.outputs_low, cfg.outputs_tristate,
        cfg.loop_power_down}, {code == 2'h3, code == 2'h2, code < 2'h2, code == 2'h0});
      rd(8'hc0, {25'h0, 2'h0, code, fs[k], 3'(k)});
    end
    u_host.xfer(1'b1, 8'h98, 8'h80);
    u_host.xfer(1'b1, 8'h9c, 8'hff);
    repeat (2) @(posedge pclk);
    chk("center and dividers", {cfg.spread_down_center_select, cfg.local_output_divider_one,
      cfg.divider_one_standby, cfg.local_output_divider_two, cfg.divider_two_standby},
      17'h101fe);
    rd(8'h9c, 33'h7f);
    repeat (2) @(posedge pclk);
    wrap_up();
  end
endmodule : tb_second_synth_loop_config_register_bank
